// ==== logic/tws_defs.vh ====
`ifndef TWS_DEFS_VH
`define TWS_DEFS_VH

// fixed upper six bits of the slave address
`define TWS_ADDR_UPPER 6'h16

// register indices, set index first, clear index second
`define TWS_IDX_VEND_LO 8'h00
`define TWS_IDX_VEND_HI 8'h01
`define TWS_IDX_PROD_LO 8'h02
`define TWS_IDX_PROD_HI 8'h03
`define TWS_IDX_CTRL1_SET 8'h04
`define TWS_IDX_CTRL1_CLR 8'h05
`define TWS_IDX_CTRL2_SET 8'h06
`define TWS_IDX_CTRL2_CLR 8'h07
`define TWS_IDX_INT_SRC 8'h08
`define TWS_IDX_LATCH_SET 8'h0A
`define TWS_IDX_LATCH_CLR 8'h0B
`define TWS_IDX_MFALL_SET 8'h0C
`define TWS_IDX_MFALL_CLR 8'h0D
`define TWS_IDX_MRISE_SET 8'h0E
`define TWS_IDX_MRISE_CLR 8'h0F
`define TWS_IDX_CTRL3_SET 8'h12
`define TWS_IDX_CTRL3_CLR 8'h13

// reset values
`define TWS_RST_CTRL1 8'h03
`define TWS_RST_CTRL2 8'h0C
`define TWS_RST_CTRL3 8'h14
`define TWS_RST_IRQ 8'h00

// field position of the pump-control enable in control 3
`define TWS_PSW_EN_BIT 6

// bits in one byte
`define TWS_BYTE_BITS 4'h8

`endif

// ==== logic/tws_slave.v ====
`timescale 1ns/1ps
`include "tws_defs.vh"

// Function
// - slave only; master drives clock, starts transfers
// - start: data falls while clock high
// - stop: data rises, clock high; ends transaction
// - receiver pulls data low on ninth clock
// - eight bits per byte, msb first
// - write: address, index, data bytes, stop
// - read: index write, restart, sequential reads
// - latch select pin on reset pin rise
// - latched level is address lsb
// - pump enable turns select pin to output
// - output drives inverse of latched level
// - address is 010110 plus latched bit
// - set and clear indices; both read back
// - pump enable bit 6, default 0
module tws_slave #(
  parameter [15:0] VENDOR_ID = 16'h1234, // arbitrary value
  parameter [15:0] PRODUCT_ID = 16'h5678 // arbitrary value
) (
  input wire core_clk,
  input wire rst,
  input wire reset_pin_n,
  input wire scl_in,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe,
  input wire adr_in,
  output reg adr_out,
  output reg adr_oe,
  input wire [7:0] int_source,
  output reg [7:0] ctrl1,
  output reg [7:0] ctrl2,
  output reg [7:0] ctrl3,
  output reg [7:0] int_latch,
  output reg [7:0] mask_fall,
  output reg [7:0] mask_rise
);

  // slave states
  localparam [2:0] ST_IDLE = 3'h0; // waiting for a start
  localparam [2:0] ST_ADDR = 3'h1; // shifting in address byte
  localparam [2:0] ST_ADDR_ACK = 3'h2; // acknowledging address
  localparam [2:0] ST_WR_BYTE = 3'h3; // shifting in index or data
  localparam [2:0] ST_WR_ACK = 3'h4; // acknowledging written byte
  localparam [2:0] ST_RD_BYTE = 3'h5; // shifting out a data byte
  localparam [2:0] ST_RD_ACK = 3'h6; // sampling master answer

  // two-flop synchronisers, plus a history stage on all but the select pin
  reg scl_s1, scl_s2, scl_d; // clock line
  reg sda_s1, sda_s2, sda_d; // data line
  reg adr_s1, adr_s2; // select pin
  reg rpn_s1, rpn_s2, rpn_d; // reset pin

  reg [2:0] state; // slave state
  reg [3:0] bit_cnt; // bits moved in current byte
  reg [7:0] shift_in; // received bits
  reg [7:0] shift_out; // bits still to send
  reg read_dir; // direction bit of the address
  reg index_phase; // next written byte is the index
  reg master_ack; // master acknowledged last read byte
  reg [7:0] reg_ptr; // register pointer
  reg adr_latched; // select level caught at reset release

  // edge events on synchronised lines
  wire scl_rise = scl_s2 & ~scl_d;
  wire scl_fall = ~scl_s2 & scl_d;
  wire start_det = scl_s2 & scl_d & sda_d & ~sda_s2;
  wire stop_det = scl_s2 & scl_d & ~sda_d & sda_s2;
  wire dev_reset = rst | ~rpn_s2;
  wire [6:0] own_addr = {`TWS_ADDR_UPPER, adr_latched};

  // read multiplexer over the register map
  function [7:0] read_reg;
    input [7:0] idx;
    begin
      case (idx)
        `TWS_IDX_VEND_LO: read_reg = VENDOR_ID[7:0];
        `TWS_IDX_VEND_HI: read_reg = VENDOR_ID[15:8];
        `TWS_IDX_PROD_LO: read_reg = PRODUCT_ID[7:0];
        `TWS_IDX_PROD_HI: read_reg = PRODUCT_ID[15:8];
        `TWS_IDX_CTRL1_SET, `TWS_IDX_CTRL1_CLR: read_reg = ctrl1;
        `TWS_IDX_CTRL2_SET, `TWS_IDX_CTRL2_CLR: read_reg = ctrl2;
        `TWS_IDX_INT_SRC: read_reg = int_source;
        `TWS_IDX_LATCH_SET, `TWS_IDX_LATCH_CLR: read_reg = int_latch;
        `TWS_IDX_MFALL_SET, `TWS_IDX_MFALL_CLR: read_reg = mask_fall;
        `TWS_IDX_MRISE_SET, `TWS_IDX_MRISE_CLR: read_reg = mask_rise;
        `TWS_IDX_CTRL3_SET, `TWS_IDX_CTRL3_CLR: read_reg = ctrl3;
        default: read_reg = 8'h00;
      endcase
    end
  endfunction

  // byte sent for the current pointer, also decides the first bit drive
  wire [7:0] rd_data = read_reg(reg_ptr);

  // set or clear bits depending on the index parity
  function [7:0] set_clr;
    input [7:0] old;
    input clr;
    input [7:0] data;
    begin
      if (clr) begin
        set_clr = old & ~data;
      end else begin
        set_clr = old | data;
      end
    end
  endfunction

  // synchronise the clock, data, select and reset pin inputs
  always @(posedge core_clk) begin
    if (rst) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_d <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_d <= 1'b1;
      adr_s1 <= 1'b0;
      adr_s2 <= 1'b0;
      rpn_s1 <= 1'b0;
      rpn_s2 <= 1'b0;
      rpn_d <= 1'b0;
    end else begin
      scl_s1 <= scl_in;
      scl_s2 <= scl_s1;
      scl_d <= scl_s2;
      sda_s1 <= sda_in;
      sda_s2 <= sda_s1;
      sda_d <= sda_s2;
      adr_s1 <= adr_in;
      adr_s2 <= adr_s1;
      rpn_s1 <= reset_pin_n;
      rpn_s2 <= rpn_s1;
      rpn_d <= rpn_s2;
    end
  end

  // select level caught at each reset pin release
  always @(posedge core_clk) begin
    if (rst) begin
      adr_latched <= 1'b0;
    end else if (rpn_s2 & ~rpn_d) begin
      adr_latched <= adr_s2;
    end
  end

  // pump switch drive, only once the level is caught
  always @(posedge core_clk) begin
    if (dev_reset) begin
      adr_oe <= 1'b0;
      adr_out <= 1'b0;
    end else begin
      adr_oe <= ctrl3[`TWS_PSW_EN_BIT];
      adr_out <= ~adr_latched;
    end
  end

  // slave protocol engine and register writes
  always @(posedge core_clk) begin
    if (dev_reset) begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      shift_in <= 8'h00;
      shift_out <= 8'h00;
      read_dir <= 1'b0;
      index_phase <= 1'b0;
      master_ack <= 1'b0;
      reg_ptr <= 8'h00;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
      ctrl1 <= `TWS_RST_CTRL1;
      ctrl2 <= `TWS_RST_CTRL2;
      ctrl3 <= `TWS_RST_CTRL3;
      int_latch <= `TWS_RST_IRQ;
      mask_fall <= `TWS_RST_IRQ;
      mask_rise <= `TWS_RST_IRQ;
    end else if (stop_det) begin
      // end of transaction, bus released
      state <= ST_IDLE;
      sda_oe <= 1'b0;
    end else if (start_det) begin
      // start or repeated start opens an address phase
      state <= ST_ADDR;
      bit_cnt <= 4'h0;
      sda_oe <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          // nothing moves until a start
          sda_oe <= 1'b0;
        end
        ST_ADDR, ST_WR_BYTE: begin
          // sample on rise, decide after eighth fall
          if (scl_rise && bit_cnt != `TWS_BYTE_BITS) begin
            shift_in <= {shift_in[6:0], sda_s2};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == `TWS_BYTE_BITS) begin
            bit_cnt <= 4'h0;
            if (state == ST_ADDR) begin
              if (shift_in[7:1] == own_addr) begin
                // address match: acknowledge
                sda_oe <= 1'b1;
                read_dir <= shift_in[0];
                index_phase <= ~shift_in[0];
                state <= ST_ADDR_ACK;
              end else begin
                // not ours: stay off the bus
                state <= ST_IDLE;
              end
            end else begin
              sda_oe <= 1'b1;
              state <= ST_WR_ACK;
              if (index_phase) begin
                // first byte sets the pointer
                reg_ptr <= shift_in;
                index_phase <= 1'b0;
              end else begin
                reg_ptr <= reg_ptr + 8'h01;
                case (reg_ptr)
                  `TWS_IDX_CTRL1_SET, `TWS_IDX_CTRL1_CLR:
                    ctrl1 <= set_clr(ctrl1, reg_ptr[0], shift_in);
                  `TWS_IDX_CTRL2_SET, `TWS_IDX_CTRL2_CLR:
                    ctrl2 <= set_clr(ctrl2, reg_ptr[0], shift_in);
                  `TWS_IDX_CTRL3_SET, `TWS_IDX_CTRL3_CLR:
                    ctrl3 <= set_clr(ctrl3, reg_ptr[0], shift_in);
                  `TWS_IDX_LATCH_SET, `TWS_IDX_LATCH_CLR:
                    int_latch <= set_clr(int_latch, reg_ptr[0], shift_in);
                  `TWS_IDX_MFALL_SET, `TWS_IDX_MFALL_CLR:
                    mask_fall <= set_clr(mask_fall, reg_ptr[0], shift_in);
                  `TWS_IDX_MRISE_SET, `TWS_IDX_MRISE_CLR:
                    mask_rise <= set_clr(mask_rise, reg_ptr[0], shift_in);
                  default: begin
                    // read-only or unmapped: dropped
                  end
                endcase
              end
            end
          end
        end
        ST_ADDR_ACK: begin
          // ninth clock ends: release, or start sending
          if (scl_fall) begin
            if (read_dir) begin
              shift_out <= rd_data;
              sda_oe <= ~rd_data[7];
              bit_cnt <= 4'h1;
              state <= ST_RD_BYTE;
            end else begin
              sda_oe <= 1'b0;
              state <= ST_WR_BYTE;
            end
          end
        end
        ST_WR_ACK: begin
          // release after the acknowledge clock
          if (scl_fall) begin
            sda_oe <= 1'b0;
            state <= ST_WR_BYTE;
          end
        end
        ST_RD_BYTE: begin
          // next bit on each fall, msb first
          if (scl_fall) begin
            if (bit_cnt == `TWS_BYTE_BITS) begin
              sda_oe <= 1'b0;
              reg_ptr <= reg_ptr + 8'h01;
              master_ack <= 1'b0;
              state <= ST_RD_ACK;
            end else begin
              shift_out <= {shift_out[6:0], 1'b0};
              sda_oe <= ~shift_out[6];
              bit_cnt <= bit_cnt + 4'h1;
            end
          end
        end
        ST_RD_ACK: begin
          // master answer decides continue or quit
          if (scl_rise) begin
            if (sda_s2) begin
              state <= ST_IDLE;
            end else begin
              master_ack <= 1'b1;
            end
          end else if (scl_fall && master_ack) begin
            shift_out <= rd_data;
            sda_oe <= ~rd_data[7];
            bit_cnt <= 4'h1;
            state <= ST_RD_BYTE;
          end
        end
        default: begin
          state <= ST_IDLE;
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

endmodule

// ==== sim/testbench.sv ====
`timescale 1ns/1ps
`include "tws_defs.vh"
// slave driven by the master model, bytes checked off a queue
module testbench;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic reset_pin_n = 1'b1;
  logic adr_lvl = 1'b0; // board level on select pin
  logic lat = 1'b0; // select level the slave should hold
  logic [7:0] int_source = 8'h00;
  logic [7:0] rnd;
  logic [8:0] exp_q[$]; // ack and byte per transfer
  logic [8:0] exp;
  int err_count = 0;
  int n_checks = 0;
  int k, w;
  wire scl, m_sda, sda, sda_out, sda_oe, adr_pin, adr_out, adr_oe, rx_ack, rx_vld;
  wire [7:0] ctrl1, ctrl2, ctrl3, rx_byte, int_latch, mask_fall, mask_rise;
  assign sda = m_sda & ~(sda_oe & ~sda_out); // pull-up
  assign adr_pin = adr_oe ? adr_out : adr_lvl; // slave wins when driving
  always #2.5 core_clk = ~core_clk;
  tws_slave tws_slave_inst (.core_clk(core_clk), .rst(rst), .reset_pin_n(reset_pin_n),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .adr_in(adr_pin),
    .adr_out(adr_out), .adr_oe(adr_oe), .int_source(int_source), .ctrl1(ctrl1),
    .ctrl2(ctrl2), .ctrl3(ctrl3), .int_latch(int_latch), .mask_fall(mask_fall),
    .mask_rise(mask_rise));
  tws_master_model tws_master_model_inst (.sda(sda), .scl(scl), .sda_o(m_sda),
    .rx_byte(rx_byte), .rx_ack(rx_ack), .rx_vld(rx_vld));
  // count and report one compare
  task chk(input logic [8:0] g, input logic [8:0] e);
    begin
      n_checks++;
      if (g !== e) begin
        err_count++;
        $display("ERROR t=%0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  task wr(input logic [7:0] b, input logic ea);
    begin
      exp_q.push_back({ea, b});
      tws_master_model_inst.xfer(b, 1'b1);
    end
  endtask
  task rd(input logic [7:0] e, input logic nack);
    begin
      exp_q.push_back({~nack, e});
      tws_master_model_inst.xfer(8'hFF, nack);
    end
  endtask
  // start, own address, register index
  task head(input logic [7:0] idx);
    begin
      tws_master_model_inst.start();
      wr({`TWS_ADDR_UPPER, lat, 1'b0}, 1'b1);
      wr(idx, 1'b1);
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  // oldest note against each finished byte
  always @(posedge rx_vld) begin
    exp = exp_q.size() ? exp_q.pop_front() : 9'h1FF;
    chk({rx_ack, rx_byte}, exp);
  end
  // hang guard
  initial begin
    #100000;
    err_count++;
    give_verdict;
  end
  initial begin
    rnd = 8'($urandom(32'h678F));
    repeat (5) @(negedge core_clk);
    rst = 1'b0;
    for (k = 0; k < 2; k++) begin
      @(negedge core_clk);
      adr_lvl = k[0];
      reset_pin_n = 1'b0;
      repeat (8) @(negedge core_clk);
      reset_pin_n = 1'b1;
      lat = k[0];
      repeat (20) @(negedge core_clk);
      chk({1'b0, ctrl1}, {1'b0, `TWS_RST_CTRL1});
      chk({1'b0, ctrl2}, {1'b0, `TWS_RST_CTRL2});
      chk({1'b0, ctrl3}, {1'b0, `TWS_RST_CTRL3});
      chk({7'h00, adr_oe, adr_pin}, {7'h00, 1'b0, lat});
      // foreign address, then a byte with no start
      tws_master_model_inst.start();
      wr({`TWS_ADDR_UPPER, ~lat, 1'b0}, 1'b0);
      wr(8'h12, 1'b0);
      tws_master_model_inst.stop();
      // set then clear via consecutive indices
      head(`TWS_IDX_CTRL3_SET);
      wr(8'h40, 1'b1);
      wr(8'h10, 1'b1);
      tws_master_model_inst.stop();
      chk({1'b0, ctrl3}, 9'h044);
      for (w = 0; w < 20 && adr_oe !== 1'b1; w++) @(negedge core_clk);
      chk({7'h00, adr_oe, adr_pin}, {7'h00, 1'b1, ~lat});
      @(negedge core_clk);
      rnd = 8'($urandom);
      int_source = 8'($urandom);
      // latch set then clear, then both masks, one write run
      head(`TWS_IDX_LATCH_SET);
      wr(rnd, 1'b1);
      wr(8'h0F, 1'b1);
      wr(rnd, 1'b1);
      wr(8'h00, 1'b1);
      wr(~rnd, 1'b1);
      tws_master_model_inst.stop();
      chk({1'b0, int_latch}, {1'b0, rnd & 8'hF0});
      chk({1'b0, mask_fall}, {1'b0, rnd});
      chk({1'b0, mask_rise}, {1'b0, ~rnd});
      head(`TWS_IDX_INT_SRC);
      tws_master_model_inst.stop();
      tws_master_model_inst.start();
      wr({`TWS_ADDR_UPPER, lat, 1'b1}, 1'b1);
      rd(int_source, 1'b0);
      rd(8'h00, 1'b0);
      rd(rnd & 8'hF0, 1'b0);
      rd(rnd & 8'hF0, 1'b0);
      rd(rnd, 1'b0);
      rd(rnd, 1'b1);
      tws_master_model_inst.stop();
    end
    give_verdict;
  end
endmodule

// ==== sim/tws_master_model.sv ====
`timescale 1ns/1ps
// bus master, open drain data, 64 ns clock only inside frames
module tws_master_model (
  input wire sda,
  output logic scl,
  output logic sda_o,
  output logic [7:0] rx_byte,
  output logic rx_ack,
  output logic rx_vld
);
  // idle: clock high, data released
  initial begin
    scl = 1'b1;
    sda_o = 1'b1;
    rx_byte = 8'h00;
    rx_ack = 1'b0;
    rx_vld = 1'b0;
  end
  // data set in low phase, sampled mid high phase
  task clk_bit(input logic b, output logic r);
    begin
      #8 sda_o = b;
      #24 scl = 1'b1;
      #16 r = sda;
      #16 scl = 1'b0;
    end
  endtask
  // master alone opens a frame
  task start;
    begin
      #8 sda_o = 1'b1;
      #24 scl = 1'b1;
      #16 sda_o = 1'b0;
      #16 scl = 1'b0;
    end
  endtask
  // also ends a refused transfer
  task stop;
    begin
      #8 sda_o = 1'b0;
      #24 scl = 1'b1;
      #16 sda_o = 1'b1;
      #32;
    end
  endtask
  // eight bits msb first, then ninth slot
  task xfer(input logic [7:0] tx, input logic last);
    integer i;
    logic r;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        clk_bit(tx[i], r);
        rx_byte[i] = r;
      end
      clk_bit(last, r);
      rx_ack = ~r;
      rx_vld = 1'b1;
      #1 rx_vld = 1'b0;
    end
  endtask
endmodule

// ==== sim/tws_slave_sva.sv ====
`timescale 1ns/1ps
// pin checks of the slave port
module tws_slave_sva (
  input wire core_clk,
  input wire rst,
  input wire reset_pin_n,
  input wire scl_in,
  input wire sda_in,
  input wire sda_out,
  input wire sda_oe,
  input wire adr_in,
  input wire adr_out,
  input wire adr_oe,
  input wire [7:0] ctrl3
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // data rises while clock high
  sequence stop_seen;
    scl_in && $rose(sda_in);
  endsequence
  // a pulled line stays pulled for eight core clocks
  sequence held_low;
    sda_oe [*8];
  endsequence
  a_drive_zero: assert property (sda_out == 1'b0)
    else $error("data line driven high");
  a_change_scl_low: assert property ($changed(sda_oe) |-> !scl_in && !$past(scl_in, 2))
    else $error("data drive moved with clock high");
  a_ack_hold: assert property ($rose(sda_oe) |-> held_low)
    else $error("pulled bit too short");
  a_stop_release: assert property (stop_seen |=> !sda_oe [*8])
    else $error("line pulled after stop");
  a_pump_follow: assert property ($changed(ctrl3[6]) |-> ##[0:2] (adr_oe == ctrl3[6]))
    else $error("pump drive not following enable");
  a_pump_off: assert property ((!ctrl3[6] && !$past(ctrl3[6])) |-> !adr_oe)
    else $error("pump drive without enable");
  a_latch_pin: assert property ($rose(reset_pin_n) ##6 1'b1 |-> adr_out != adr_in)
    else $error("select level not latched");
  a_rst_clear: assert property ($fell(rst) |-> ##3 adr_out)
    else $error("latched bit not cleared");
endmodule

bind tws_slave tws_slave_sva tws_slave_sva_inst (.core_clk(core_clk), .rst(rst),
  .reset_pin_n(reset_pin_n), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .adr_in(adr_in), .adr_out(adr_out), .adr_oe(adr_oe), .ctrl3(ctrl3));
